/* File: logic/seq_engine_pkg.sv */
// Shared constants, types and carriers for the rail sequencing engine.
// Assumes one 200 MHz clock; all users import the whole package.
`default_nettype none

package seq_engine_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int PAGES = 32;          // Rails handled by the engine
  localparam int IN_PINS = 32;        // General input pins
  localparam int PAGE_W = 5;          // Page index width
  localparam int TMR_W = 16;          // Per-page tick counter width
  localparam int RSQ_W = 4;           // Resequence counter width
  localparam int CODE_W = 8;          // Encoded duration byte

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 5;   // Period of ref_clk_i
  localparam int TICK_PERIOD_NS = 1000; // One timer tick
  localparam int TICK_CYCLES =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Timeout action byte layout and codes
  localparam int ON_ACT_LSB = 0;      // Sequence-on action, bits 1:0
  localparam int OFF_ACT_LSB = 2;     // Sequence-off action, bits 3:2
  localparam logic [1:0] ACT_WAIT = 2'h0;
  localparam logic [1:0] ACT_CONTINUE = 2'h1;
  localparam logic [1:0] ACT_RESEQ = 2'h2;

  // Enable pin mode code meaning input; such a write is refused
  localparam logic [1:0] EN_MODE_INPUT = 2'h0;
  // A zero duration code switches timeout monitoring off
  localparam logic [CODE_W-1:0] CODE_DISABLED = 8'h00;

  // Log record kinds
  localparam logic [1:0] LOG_ON_TIMEOUT = 2'h1;
  localparam logic [1:0] LOG_OFF_TIMEOUT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Per-page sequencing_setup_command image
  typedef struct packed {
    logic [7:0] en_pin_id;            // Which pin drives the rail enable
    logic en_pol;                     // 1: enable pin active high
    logic [1:0] en_mode;              // Enable pin drive mode
    logic [IN_PINS-1:0] pin_on_mask;  // input_pin_on_dependency_mask
    logic [IN_PINS-1:0] pin_off_mask; // input_pin_off_dependency_mask
    logic [7:0] timeout_action;       // sequencing_timeout_action
    logic [CODE_W-1:0] on_timeout;    // sequence_on_timeout_value
    logic [CODE_W-1:0] off_timeout;   // Sequence-off timeout code
    logic [PAGES-1:0] page_on_mask;   // Pages that must be power-good
    logic [PAGES-1:0] page_off_mask;  // Pages that must have left it
    logic [PAGES-1:0] fault_slaves;   // Pages dragged along on reseq
  } seq_cfg_t;

  localparam int CFG_W = $bits(seq_cfg_t);

  // Timeout log record
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [PAGE_W-1:0] page;
  } log_rec_t;

  // Rail states, Gray coded in declaration order from ST_OFF round to ST_FAULT
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_WAIT_ON = 3'h1,
    ST_ON_DLY = 3'h3,
    ST_ON = 3'h2,
    ST_WAIT_OFF = 3'h6,
    ST_OFF_DLY = 3'h7,
    ST_RESEQ = 3'h5,
    ST_FAULT = 3'h4
  } rail_state_t;

  // Duration decoder; the real 8-bit encoding lives elsewhere, so this
  // linear stand-in is the single place to swap it.
  function automatic logic [TMR_W-1:0] decode_time(
    input logic [CODE_W-1:0] code
  );
    return {{(TMR_W-CODE_W){1'b0}}, code};
  endfunction : decode_time

endpackage : seq_engine_pkg

`default_nettype wire

/* File: logic/cfg_store.sv */
// Configuration store: one write port, two read ports with registered data.
// Assumes a single clock; contents are undefined until written.
`default_nettype none

module cfg_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic ref_clk_i,
  // Write port
  input wire logic wr_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Scan read port
  input wire logic [AW-1:0] a_addr_i,
  output logic [WIDTH-1:0] a_data_o,
  // Host read port
  input wire logic [AW-1:0] b_addr_i,
  output logic [WIDTH-1:0] b_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array, no reset on purpose

  ////////////////////////////////////////////////////////////////////////////
  // Write and both registered reads; a read of the address being written
  // returns the old word
  always_ff @(posedge ref_clk_i) begin
    if (wr_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    a_data_o <= mem[a_addr_i];
    b_data_o <= mem[b_addr_i];
  end

endmodule : cfg_store

`default_nettype wire

/* File: logic/rail_sequence_dependency_engine.sv */
// Rail sequencing engine: per-page enable decisions from dependencies,
// host run requests, delays and sequencing timeouts.
// Assumes host-side inputs share ref_clk_i; pins arrive asynchronously.
//
// How it works
// RQ1: Turn on only when all on-conditions hold.
// RQ2: Once on, on-dependencies never turn off.
// RQ3: Needs host run request and dependencies, any order.
// RQ4: No-control setting still waits for dependencies.
// RQ5: Turn-on delay starts after command and dependencies.
// RQ6: Wait off-dependencies, then turn-off delay, unless immediate.
// RQ7: After fault, low-then-high toggle needed to restart.
// RQ8: Enable pin inactive until masks and delay allow.
// RQ9: Input mode writes are refused with NACK.
// RQ10: Per-page 32-bit input pin on/off masks.
// RQ11: Selected input pins high before enable, then ignored.
// RQ12: Selected input pins low before disable, then ignored.
// RQ13: Each timeout updates status and fault log.
// RQ14: Off timeout action 01 continues, others wait.
// RQ15: On timeout action 01 continues, 00/11 wait.
// RQ16: On timeout action 10 resequences rail and slaves.
// RQ17: On-timeout status bit; zero code disables it.
// RQ18: Config write drops enable, then re-evaluates rail.
// RQ19: Selected pages power-good before enable.
// RQ20: Off-timeout status bit; zero code disables it.
// RQ21: Timeout bytes decoded to ticks by a decoder.
`default_nettype none

module rail_sequence_dependency_engine
  import seq_engine_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Host configuration port
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [PAGE_W-1:0] cfg_page_i,
  input wire seq_cfg_t cfg_wdata_i,
  output logic cfg_ack_o,
  output logic cfg_nack_o,
  output logic cfg_rvalid_o,
  output seq_cfg_t cfg_rdata_o,
  // Host on/off mechanism, per page; resequence gap and limit shared by all pages
  input wire logic [PAGES-1:0] run_cmd_i,
  input wire logic [PAGES-1:0] onoff_none_i,
  input wire logic [PAGES-1:0] immediate_off_i,
  input wire logic [PAGES-1:0] fault_shutdown_i,
  input wire logic [PAGES-1:0][CODE_W-1:0] turn_on_delay_setting_i,
  input wire logic [PAGES-1:0][CODE_W-1:0] turn_off_delay_setting_i,
  input wire logic [CODE_W-1:0] reseq_gap_i,
  input wire logic [RSQ_W-1:0] reseq_max_i,
  // Pins
  input wire logic [IN_PINS-1:0] general_input_pin_i,
  input wire logic ctrl_pin_i,
  input wire logic [PAGES-1:0] power_good_i,
  // Status
  input wire logic [PAGES-1:0] status_clr_i,
  output logic [PAGES-1:0] rail_enable_o,
  output logic [PAGES-1:0] on_timeout_o,
  output logic [PAGES-1:0] off_timeout_o,
  output logic [PAGES-1:0] latched_off_o,
  output log_rec_t fault_log_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  logic [IN_PINS-1:0] pin_meta_reg, pin_s_reg;
  logic [PAGES-1:0] pg_meta_reg, pg_s_reg;
  logic ctrl_meta_reg, ctrl_s_reg;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_reg <= '0;
      pin_s_reg <= '0;
      pg_meta_reg <= '0;
      pg_s_reg <= '0;
      ctrl_meta_reg <= 1'b0;
      ctrl_s_reg <= 1'b0;
    end else begin
      pin_meta_reg <= general_input_pin_i;
      pin_s_reg <= pin_meta_reg;
      pg_meta_reg <= power_good_i;
      pg_s_reg <= pg_meta_reg;
      ctrl_meta_reg <= ctrl_pin_i;
      ctrl_s_reg <= ctrl_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider
  localparam int TICK_W = $clog2(TICK_CYC + 1);
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick_reg;               // One-cycle pulse per tick period

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_W'(TICK_CYC - 1));
      tick_cnt_reg <= (tick_cnt_reg == TICK_W'(TICK_CYC - 1)) ?
                      '0 : tick_cnt_reg + TICK_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page scan: one page is evaluated per cycle, so a full round takes
  // PAGES cycles. Trade-off: one comparator set instead of 32, at the cost
  // of up to a round of latency and missing pin pulses shorter than that.
  logic [PAGE_W-1:0] scan_ptr_reg;  // Page being fetched
  logic [PAGE_W-1:0] vis_pg_reg;    // Page being evaluated
  logic vis_ok_reg;                 // Fetched data is valid
  seq_cfg_t c;                      // Configuration of visited page

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_ptr_reg <= '0;
      vis_pg_reg <= '0;
      vis_ok_reg <= 1'b0;
    end else begin
      scan_ptr_reg <= scan_ptr_reg + PAGE_W'(1);
      vis_pg_reg <= scan_ptr_reg;
      vis_ok_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host write decode
  wire wr_bad = cfg_wr_i && (cfg_wdata_i.en_mode == EN_MODE_INPUT); // RQ9
  wire wr_take = cfg_wr_i && !wr_bad;

  cfg_store #(
    .WIDTH(CFG_W),
    .DEPTH(PAGES),
    .AW(PAGE_W)
  ) u_store (
    .ref_clk_i(ref_clk_i),
    .wr_i(wr_take),
    .wr_addr_i(cfg_page_i),
    .wr_data_i(cfg_wdata_i),
    .a_addr_i(scan_ptr_reg),
    .a_data_o(c),
    .b_addr_i(cfg_page_i),
    .b_data_o(cfg_rdata_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-page state
  rail_state_t state_reg [PAGES];
  logic [TMR_W-1:0] timer_reg [PAGES];
  logic [RSQ_W-1:0] rsq_cnt_reg [PAGES];
  logic [PAGES-1:0] tick_pend_reg;  // Tick seen since last visit
  logic [PAGES-1:0] cfg_new_reg;    // Config written, drop enable
  logic [PAGES-1:0] cfg_valid_reg;  // Page has been configured
  logic [PAGES-1:0] fault_pend_reg; // Fault shutdown pending
  logic [PAGES-1:0] slave_pend_reg; // Resequence shutdown pending
  logic [PAGES-1:0] low_seen_reg;   // Restart toggle went low

  ////////////////////////////////////////////////////////////////////////////
  // Dependency evaluation for the visited page
  wire [PAGE_W-1:0] v = vis_pg_reg;
  wire rail_cfg = vis_ok_reg && cfg_valid_reg[v];
  wire pin_on_ok = &(~c.pin_on_mask | pin_s_reg);    // RQ11
  wire pin_off_ok = &(~c.pin_off_mask | ~pin_s_reg); // RQ12
  wire pg_on_ok = &(~c.page_on_mask | pg_s_reg);     // RQ19
  wire pg_off_ok = &(~c.page_off_mask | ~pg_s_reg);
  wire deps_on = pin_on_ok && pg_on_ok;              // RQ1
  wire deps_off = pin_off_ok && pg_off_ok;
  wire run_req = onoff_none_i[v] || run_cmd_i[v];    // RQ4
  wire tick_v = tick_pend_reg[v];
  wire [TMR_W-1:0] tmr = timer_reg[v];
  wire [TMR_W-1:0] tmr_inc = (tick_v && tmr != '1) ? tmr + TMR_W'(1) : tmr;
  wire [TMR_W-1:0] on_lim = decode_time(c.on_timeout);   // RQ21
  wire [TMR_W-1:0] off_lim = decode_time(c.off_timeout);
  wire [1:0] on_act = c.timeout_action[ON_ACT_LSB +: 2];
  wire [1:0] off_act = c.timeout_action[OFF_ACT_LSB +: 2];
  wire on_to_hit = tick_v && (c.on_timeout != CODE_DISABLED) &&
                   (tmr_inc == on_lim) && (tmr != on_lim);  // RQ17
  wire off_to_hit = tick_v && (c.off_timeout != CODE_DISABLED) &&
                    (tmr_inc == off_lim) && (tmr != off_lim); // RQ20
  wire rst_low = !ctrl_s_reg || !run_req || !pin_on_ok;
  rail_state_t cur;
  assign cur = state_reg[v];

  rail_state_t nxt;                 // Next state of visited page
  logic [TMR_W-1:0] tmr_next;
  logic [RSQ_W-1:0] rsq_next;
  logic en_next;                    // Logical enable of visited page
  logic low_next;
  logic on_to_evt, off_to_evt, rsq_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the visited page
  always_comb begin
    nxt = cur;
    tmr_next = tmr_inc;
    rsq_next = rsq_cnt_reg[v];
    en_next = 1'b0;
    low_next = low_seen_reg[v];
    on_to_evt = 1'b0;
    off_to_evt = 1'b0;
    rsq_evt = 1'b0;
    case (cur)
      ST_OFF: begin
        tmr_next = '0;
        if (run_req) begin
          nxt = ST_WAIT_ON;
        end
      end
      ST_WAIT_ON: begin
        if (!run_req) begin
          nxt = ST_OFF;
        end else if (deps_on) begin
          nxt = ST_ON_DLY;              // RQ5
          tmr_next = '0;
        end else if (on_to_hit) begin
          on_to_evt = 1'b1;             // RQ13
          if (on_act == ACT_CONTINUE) begin
            nxt = ST_ON_DLY;            // RQ15
            tmr_next = '0;
          end else if (on_act == ACT_RESEQ) begin
            nxt = ST_RESEQ;             // RQ16
            tmr_next = '0;
            rsq_evt = 1'b1;
          end
        end
      end
      ST_ON_DLY: begin
        if (!run_req) begin
          nxt = ST_OFF;                 // RQ3
        end else if (tmr >= decode_time(turn_on_delay_setting_i[v])) begin
          nxt = ST_ON;                  // RQ8
          en_next = 1'b1;
          rsq_next = '0;
        end
      end
      ST_ON: begin
        en_next = 1'b1;                 // RQ2
        tmr_next = '0;
        if (!run_req) begin
          nxt = ST_WAIT_OFF;
        end
      end
      ST_WAIT_OFF: begin
        en_next = 1'b1;
        if (run_req) begin
          nxt = ST_ON;
        end else if (deps_off) begin
          nxt = ST_OFF_DLY;             // RQ6
          tmr_next = '0;
        end else if (off_to_hit) begin
          off_to_evt = 1'b1;            // RQ13
          if (off_act == ACT_CONTINUE) begin
            nxt = ST_OFF_DLY;           // RQ14
            tmr_next = '0;
          end
        end
      end
      ST_OFF_DLY: begin
        en_next = 1'b1;
        if (tmr >= decode_time(turn_off_delay_setting_i[v])) begin
          nxt = ST_OFF;
          en_next = 1'b0;
        end
      end
      ST_RESEQ: begin
        if (tmr >= decode_time(reseq_gap_i)) begin
          if (rsq_cnt_reg[v] < reseq_max_i) begin
            nxt = ST_OFF;               // RQ16
            rsq_next = rsq_cnt_reg[v] + RSQ_W'(1);
          end else begin
            nxt = ST_FAULT;
            low_next = 1'b0;
          end
        end
      end
      ST_FAULT: begin
        tmr_next = '0;
        if (rst_low) begin
          low_next = 1'b1;              // RQ7
        end else if (low_seen_reg[v]) begin
          nxt = ST_OFF;                 // RQ7
          low_next = 1'b0;
        end
      end
      default: begin
        nxt = ST_OFF;
      end
    endcase
    // Overrides, strongest first
    if (fault_pend_reg[v]) begin
      nxt = ST_FAULT;
      en_next = 1'b0;
      low_next = 1'b0;
    end else if (cur != ST_FAULT &&
                 (cfg_new_reg[v] || slave_pend_reg[v])) begin
      nxt = ST_OFF;                     // RQ18
      en_next = 1'b0;
    end else if (immediate_off_i[v] && en_next) begin
      nxt = ST_OFF;                     // RQ6
      en_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Visit selection and flag updates; a set always wins over a clear
  wire [PAGES-1:0] vis_sel = vis_ok_reg ?
                             ({{(PAGES-1){1'b0}}, 1'b1} << v) : '0;
  wire [PAGES-1:0] wr_sel = wr_take ?
                            ({{(PAGES-1){1'b0}}, 1'b1} << cfg_page_i) : '0;
  wire [PAGES-1:0] up_sel = rail_cfg ? vis_sel : '0;
  wire [PAGES-1:0] slave_set = rsq_evt && rail_cfg ?
                               (c.fault_slaves & ~vis_sel) : '0;
  wire [PAGES-1:0] on_to_set = (rail_cfg && on_to_evt) ? vis_sel : '0;
  wire [PAGES-1:0] off_to_set = (rail_cfg && off_to_evt) ? vis_sel : '0;
  wire pin_level = c.en_pol ? en_next : !en_next;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_pend_reg <= '0;
      cfg_new_reg <= '0;
      cfg_valid_reg <= '0;
      fault_pend_reg <= '0;
      slave_pend_reg <= '0;
      on_timeout_o <= '0;
      off_timeout_o <= '0;
    end else begin
      tick_pend_reg <= (tick_pend_reg & ~vis_sel) | {PAGES{tick_reg}};
      cfg_new_reg <= (cfg_new_reg & ~up_sel) | wr_sel;  // RQ18
      cfg_valid_reg <= cfg_valid_reg | wr_sel;
      fault_pend_reg <= (fault_pend_reg & ~up_sel) | fault_shutdown_i;
      slave_pend_reg <= (slave_pend_reg & ~up_sel) | slave_set;
      on_timeout_o <= (on_timeout_o & ~status_clr_i) | on_to_set;
      off_timeout_o <= (off_timeout_o & ~status_clr_i) | off_to_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-page state write-back; unconfigured pages stay off
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < PAGES; i++) begin
        state_reg[i] <= ST_OFF;
        timer_reg[i] <= '0;
        rsq_cnt_reg[i] <= '0;
      end
      low_seen_reg <= '0;
      rail_enable_o <= '0;
      latched_off_o <= '0;
    end else if (rail_cfg) begin
      state_reg[v] <= nxt;
      timer_reg[v] <= tmr_next;
      rsq_cnt_reg[v] <= rsq_next;
      low_seen_reg[v] <= low_next;
      rail_enable_o[v] <= pin_level;    // RQ8
      latched_off_o[v] <= (nxt == ST_FAULT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host answers and timeout log
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ack_o <= 1'b0;
      cfg_nack_o <= 1'b0;
      cfg_rvalid_o <= 1'b0;
      fault_log_o <= '0;
    end else begin
      cfg_ack_o <= wr_take;
      cfg_nack_o <= wr_bad;             // RQ9
      cfg_rvalid_o <= cfg_rd_i;
      fault_log_o.valid <= rail_cfg && (on_to_evt || off_to_evt); // RQ13
      fault_log_o.kind <= on_to_evt ? LOG_ON_TIMEOUT : LOG_OFF_TIMEOUT;
      fault_log_o.page <= v;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence on_timeout_seen;
    rail_cfg && on_to_evt;
  endsequence

  sequence flag_and_log;
    on_timeout_o[$past(v)] && fault_log_o.valid &&
    fault_log_o.kind == LOG_ON_TIMEOUT;
  endsequence

  and_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ1
    rail_cfg && cur == ST_WAIT_ON && nxt == ST_ON_DLY |->
    deps_on || (on_to_hit && on_act == ACT_CONTINUE))
    else $error("turn-on delay began without dependencies");

  on_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ2
    rail_cfg && cur == ST_ON && run_req && !fault_pend_reg[v] &&
    !cfg_new_reg[v] && !slave_pend_reg[v] && !immediate_off_i[v] |->
    nxt == ST_ON)
    else $error("rail left on state while still requested");

  run_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ3
    rail_cfg && nxt == ST_ON_DLY && cur != ST_ON_DLY |-> run_req)
    else $error("turn-on delay began without run request");

  off_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ6
    rail_cfg && cur == ST_WAIT_OFF && nxt == ST_OFF_DLY |->
    deps_off || (off_to_hit && off_act == ACT_CONTINUE))
    else $error("turn-off delay began without off dependencies");

  fault_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ7
    rail_cfg && cur == ST_FAULT && !low_seen_reg[v] |-> nxt == ST_FAULT)
    else $error("fault latch released without a toggle");

  en_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ8
    rail_cfg && en_next |->
    nxt == ST_ON || nxt == ST_WAIT_OFF || nxt == ST_OFF_DLY)
    else $error("enable active outside on states");

  nack_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ9
    wr_bad |=> cfg_nack_o && !cfg_ack_o ##1 (!cfg_nack_o || $past(wr_bad)))
    else $error("input mode write not refused");

  timeout_log_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ13
    on_timeout_seen |=> flag_and_log)
    else $error("on timeout without status and log");

  cfg_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RQ18
    rail_cfg && cfg_new_reg[v] && cur != ST_FAULT |-> !en_next)
    else $error("config write did not drop enable");

endmodule : rail_sequence_dependency_engine

`default_nettype wire

/* File: bench/host_model.sv */
// Host model: issues configuration writes and reads to the engine.
// Assumes registered answers one cycle after the request edge.
`default_nettype none

module host_model
  import seq_engine_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Requests
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [PAGE_W-1:0] page_o,
  output seq_cfg_t data_o,
  // Answers
  input wire logic ack_i,
  input wire logic nack_i,
  input wire logic rvalid_i,
  input wire seq_cfg_t rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    page_o = '0;
    data_o = '0;
  end

  // One write beat; ans gathers {ack, nack} over the answer window
  task automatic wr(input logic [PAGE_W-1:0] p, input seq_cfg_t d,
                    output logic [1:0] ans);
    @(posedge ref_clk_i);
    #1;
    cfg_wr_o = 1'b1;
    page_o = p;
    data_o = d;
    @(posedge ref_clk_i);
    #1;
    cfg_wr_o = 1'b0;
    data_o = ~d;  // A released bus must not show the old image
    ans = {ack_i, nack_i};
    @(posedge ref_clk_i);
    #1;
    ans = ans | {ack_i, nack_i};
  endtask : wr

  // One read beat; data taken in the valid cycle
  task automatic rd(input logic [PAGE_W-1:0] p, output seq_cfg_t d);
    @(posedge ref_clk_i);
    #1;
    cfg_rd_o = 1'b1;
    page_o = p;
    @(posedge ref_clk_i);
    #1;
    cfg_rd_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : host_model

`default_nettype wire

/* File: bench/test_rail_sequence_dependency_engine.sv */
// Self-checking bench for the rail sequencing engine.
// Assumes host_model drives the configuration port; power-good echoes the rail enables.
`default_nettype none

module test_rail_sequence_dependency_engine
  import seq_engine_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn_n = 1'b0;
  logic [PAGES-1:0] run = '0, none_r = '0, clr = '0, flt = '0;
  logic [IN_PINS-1:0] general_input_pin = '0;
  logic [PAGES-1:0][CODE_W-1:0] ton = '0, toff = '0;
  logic [PAGES-1:0] en, ont, offt, lat;
  logic wr, rd, ack, nack, rv;
  logic [PAGE_W-1:0] pg_sel;
  seq_cfg_t wd, rdat, c, got;
  log_rec_t flog, last_log = '0;
  logic [1:0] ans;
  int fail_count = 0, checks_done = 0;
  wire logic [PAGES-1:0] pgood = en;  // Rails come good as soon as enabled

  rail_sequence_dependency_engine #(.TICK_CYC(2)) uut (.ref_clk_i(clk),
    .rstn_i(rstn_n), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_page_i(pg_sel),
    .cfg_wdata_i(wd), .cfg_ack_o(ack), .cfg_nack_o(nack), .cfg_rvalid_o(rv),
    .cfg_rdata_o(rdat), .run_cmd_i(run), .onoff_none_i(none_r),
    .immediate_off_i('0), .fault_shutdown_i(flt),
    .turn_on_delay_setting_i(ton), .turn_off_delay_setting_i(toff),
    .reseq_gap_i(8'h00), .reseq_max_i(4'h0), .general_input_pin_i(general_input_pin),
    .ctrl_pin_i(1'b1), .power_good_i(pgood), .status_clr_i(clr),
    .rail_enable_o(en), .on_timeout_o(ont), .off_timeout_o(offt),
    .latched_off_o(lat), .fault_log_o(flog));
  host_model host (.ref_clk_i(clk), .cfg_wr_o(wr), .cfg_rd_o(rd),
    .page_o(pg_sel), .data_o(wd), .ack_i(ack), .nack_i(nack),
    .rvalid_i(rv), .rdata_i(rdat));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and capture of the latest log pulse
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (flog.valid === 1'b1) last_log <= flog;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Bounded wait for an enable (sel=0) or on-timeout flag (sel=1)
  task automatic wait_bit(input int p, input bit sel, input logic v);
    // Sample just after each edge so registered outputs have settled
    for (int i = 0; i < 500 && (sel ? ont[p] : en[p]) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk($sformatf("page %0d sel %0d", p, sel), v, sel ? ont[p] : en[p]);
  endtask : wait_bit

  task automatic t_nack();
    c = '0;
    host.wr(5'h00, c, ans);
    chk("nack", 2'h1, ans);
  endtask : t_nack

  task automatic t_on();
    c = '0;
    c.en_pol = 1'b1;
    c.en_mode = 2'h1;
    c.page_on_mask = 32'h1;
    none_r[2] = 1'b1;
    host.wr(5'h02, c, ans);
    c.page_on_mask = '0;
    c.pin_on_mask = 32'h8;
    c.pin_off_mask = 32'h10;
    host.wr(5'h00, c, ans);
    chk("ack", 2'h2, ans);
    host.rd(5'h00, got);
    chk("rd mask", 32'h8, got.pin_on_mask);
    run[0] = 1'b1;
    repeat (200) @(posedge clk);
    chk("held", 32'h0, en);
    #1 general_input_pin[3] = 1'b1;
    wait_bit(0, 0, 1'b1);
    wait_bit(2, 0, 1'b1);
    general_input_pin = 32'h10;
    run[0] = 1'b0;
    repeat (200) @(posedge clk);
    chk("off wait", 1, en[0]);
    #1 general_input_pin = '0;
    wait_bit(0, 0, 1'b0);
  endtask : t_on

  task automatic t_tmo(input logic [7:0] act);
    c = '0;
    c.en_pol = 1'b1;
    c.en_mode = 2'h2;
    c.pin_on_mask = 32'h20;
    c.timeout_action = act;
    c.on_timeout = 8'h03;
    run[1] = 1'b1;
    host.wr(5'h01, c, ans);
    wait_bit(1, 1, 1'b1);
    // The log pulse is captured one edge after the flag rises
    @(posedge clk);
    #1;
    chk("log", {LOG_ON_TIMEOUT, 5'h01}, {last_log.kind, last_log.page});
    #1 clr[1] = 1'b1;
    @(posedge clk);
    #1 clr[1] = 1'b0;
    wait_bit(1, 0, act == 8'h01);
  endtask : t_tmo

  // Fault latch on page 0, then release by a low-then-high run request
  task automatic t_fault();
    #1 general_input_pin[3] = 1'b1;
    run[0] = 1'b1;
    wait_bit(0, 0, 1'b1);
    flt[0] = 1'b1;
    @(posedge clk);
    #1 flt[0] = 1'b0;
    wait_bit(0, 0, 1'b0);
    repeat (80) @(posedge clk);
    #1;
    chk("latched", 1, lat[0]);
    run[0] = 1'b0;
    repeat (80) @(posedge clk);
    #1;
    chk("still off", 0, en[0]);
    run[0] = 1'b1;
    wait_bit(0, 0, 1'b1);
    chk("unlatched", 0, lat[0]);
  endtask : t_fault

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn_n = 1'b1;
    t_nack();
    t_on();
    t_fault();
    t_tmo(8'h00);
    t_tmo(8'h01);
    wrap_up();
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule : test_rail_sequence_dependency_engine

`default_nettype wire
